// *** logic/ssr_pkg.sv ***
/*
 Constants, response layout and state type for the squib SPI response formatter.
 Assumes a 100 MHz core clock and a 16-bit SPI frame shifted MSB first.
*/
// How it works
// - Top two response bits give type: 00 register, 01 echo, 10 fault, 11 status.
// - Register response puts the five-bit register address in D12..D8.
// - Register response D13 repeats the host read/write bit.
// - Register response low byte carries the selected fault or resistance register.
// - Echo response D12 shows the deployment-enable input level.
// - Echo and status D11..D8 report arming pairs 6/7, 4/5, 2/3, 0/1.
// - Arming flag includes input-started stretch, never a command-started stretch.
// - Arming flag changes only when its de-glitch timer expires.
// - Echo deploy bits copy latest accepted command, overwritten each time.
// - With deployment-enable negated, deploy commands are ignored; echo bits clear, but hold their last value while any channel is busy.
// - Failed parity gives prefix 10 with the other fourteen bits all zero.
// - Status response is the default reply.
// - Status D13 is the diagnostic fault, only for channels in the report mask.
// - Status D12 is 0 while diagnostic runs, 1 when done or never started.
// - Completion ignores the short-between-loops test progress.
// - Deploy-success flag sets when the 2 ms or 4 ms period elapses.
// - A set success flag refuses deploys on that channel until cleared.
// - Every host word carries odd parity over all sixteen bits.
// - Monitor write with enable clears success flags for ones, keeps zeros.

package ssr_pkg;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int NCH = 8;
	localparam int NPAIR = 4;
	localparam int ADDR_W = 5;
	localparam int B_MODE_HI = 15;
	localparam int B_MODE_LO = 14;
	localparam int B_RW = 13;
	localparam int B_ADDR_HI = 12;
	localparam int B_ADDR_LO = 8;
	localparam int B_WR_EN = 12;
	localparam int B_DATA_HI = 7;
	localparam int IX_ENABLE = 4;
	localparam int IX_TGL = 5;
	localparam int NSYNC = 6;

	localparam logic [1:0] RSP_REG = 2'h0;
	localparam logic [1:0] RSP_CMD = 2'h1;
	localparam logic [1:0] RSP_FLT = 2'h2;
	localparam logic [1:0] RSP_STAT = 2'h3;
	localparam logic [1:0] REQ_REG = 2'h0;
	localparam logic [1:0] REQ_CMD = 2'h1;
	localparam logic [1:0] REQ_DIAG = 2'h2;
	localparam logic [1:0] REQ_MON = 2'h3;
	localparam logic [13:0] FLT_FILL = 14'h0000;
	localparam logic [15:0] RESP_RST = 16'hd000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_DEPLOY_SHORT_US = 2000;
	localparam int T_DEPLOY_LONG_US = 4000;
	localparam int T_DEGLITCH_US = 10;
	localparam int T_STRETCH_US = 100;
	localparam int DEP_SHORT_CYC = T_DEPLOY_SHORT_US * CLK_MHZ;
	localparam int DEP_LONG_CYC = T_DEPLOY_LONG_US * CLK_MHZ;
	localparam int DEGLITCH_CYC = T_DEGLITCH_US * CLK_MHZ;
	localparam int STRETCH_CYC = T_STRETCH_US * CLK_MHZ;

	typedef enum logic [1:0] {CS_IDLE, CS_DECODE, CS_REGW} ssr_state_t;
endpackage : ssr_pkg

// *** logic/ssr_link.sv ***
/*
 SPI shifter on the link clock: takes in host words, shifts out the response.
 Assumes host drives MOSI on falling sclk, samples MISO on falling sclk,
 and that resp_word is stable from frame start to its first rising sclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_link
	import ssr_pkg::*;
(
	input wire logic sclk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic [WORD_W-1:0] resp_word,
	output logic miso,
	output logic [WORD_W-1:0] rx_word,
	output logic rx_tgl
);
	typedef struct packed {
		logic [3:0] cnt;
		logic [WORD_W-1:0] sh_out;
		logic [WORD_W-1:0] sh_in;
		logic [WORD_W-1:0] rx;
		logic tgl;
		logic miso;
	} ssr_link_t;

	ssr_link_t s, n;

	// ----------------------------------------------------------------
	// Shift logic
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		if (cs_n) begin
			n.cnt = 4'h0;
		end else begin
			if (s.cnt == 4'h0) begin
				n.miso = resp_word[WORD_W-1];
				n.sh_out = {resp_word[WORD_W-2:0], 1'b0};
			end else begin
				n.miso = s.sh_out[WORD_W-1];
				n.sh_out = {s.sh_out[WORD_W-2:0], 1'b0};
			end
			n.sh_in = {s.sh_in[WORD_W-2:0], mosi};
			if (s.cnt == 4'hf) begin
				n.rx = {s.sh_in[WORD_W-2:0], mosi};
				n.tgl = ~s.tgl;
			end
			n.cnt = s.cnt + 4'h1;
		end
	end

	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign miso = s.miso;
	assign rx_word = s.rx;
	assign rx_tgl = s.tgl;
endmodule : ssr_link
`default_nettype wire

// *** logic/ssr_formatter.sv ***
/*
 Response formatter: decodes host words, keeps deploy, arming and diagnostic
 flags, and builds the next 16-bit MISO word.
 Assumes the diagnostic sequencer and register file sit on clk, and that
 frames are at least 80 ns apart so the response is settled before use.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_formatter
	import ssr_pkg::*;
#(
	parameter int DEP_SHORT = DEP_SHORT_CYC,
	parameter int DEP_LONG = DEP_LONG_CYC,
	parameter int DEGLITCH = DEGLITCH_CYC,
	parameter int STRETCH = STRETCH_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic deploy_enable_input,
	input wire logic arming_pair_zero_one,
	input wire logic arming_pair_two_three,
	input wire logic arming_pair_four_five,
	input wire logic arming_pair_six_seven,
	input wire logic deploy_time_long,
	input wire logic [NCH-1:0] diag_chan_fault,
	input wire logic [NCH-1:0] fault_report_channel_mask,
	input wire logic [NCH-1:0] diag_chan_done,
	input wire logic [7:0] reg_rd_data,
	output logic miso,
	output logic [NCH-1:0] deploy_start,
	output logic [NCH-1:0] deploy_success,
	output logic [NPAIR-1:0] arming_status,
	output logic diag_start,
	output logic [NCH-1:0] diag_channels,
	output logic [ADDR_W-1:0] reg_rd_addr
);
	localparam int DW = $clog2(DEP_LONG + 1);
	localparam int GW = $clog2(DEGLITCH + 1);
	localparam int SW = $clog2(STRETCH + 1);

	typedef struct packed {
		ssr_state_t st;
		logic [NSYNC-1:0] p1;
		logic [NSYNC-1:0] p2;
		logic [NSYNC-1:0] p3;
		logic [NSYNC-1:0] pv;
		logic [NPAIR-1:0] arm;
		logic [NPAIR-1:0][GW-1:0] gcnt;
		logic [NPAIR-1:0][SW-1:0] scnt;
		logic [WORD_W-1:0] word;
		logic [WORD_W-1:0] resp;
		logic [NCH-1:0] echo;
		logic [NCH-1:0] succ;
		logic [NCH-1:0] busy;
		logic [NCH-1:0] lng;
		logic [NCH-1:0] pend;
		logic [NCH-1:0] fire;
		logic [NCH-1:0] dchan;
		logic [NCH-1:0][DW-1:0] dcnt;
		logic dstart;
		logic [ADDR_W-1:0] raddr;
		logic rrw;
	} ssr_core_t;

	ssr_core_t s, n;
	logic [WORD_W-1:0] rx_word;
	logic rx_tgl;
	logic rx_ev;
	logic par_ok;
	logic [1:0] req;
	logic [NCH-1:0] succ_set;
	logic [NCH-1:0] succ_clr;
	logic [WORD_W-1:0] stat_word;

	// ----------------------------------------------------------------
	// Link side shifter
	// ----------------------------------------------------------------
	ssr_link u_link (
		.sclk(sclk),
		.nrst(nrst),
		.cs_n(cs_n),
		.mosi(mosi),
		.resp_word(s.resp),
		.miso(miso),
		.rx_word(rx_word),
		.rx_tgl(rx_tgl)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		succ_set = '0;
		succ_clr = '0;
		n.p1 = {rx_tgl, deploy_enable_input, arming_pair_six_seven,
			arming_pair_four_five, arming_pair_two_three, arming_pair_zero_one};
		n.p2 = s.p1;
		n.p3 = s.p2;
		for (int k = 0; k < NSYNC; k++) begin
			if (s.p2[k] == s.p3[k]) begin
				n.pv[k] = s.p3[k];
			end
		end
		rx_ev = (s.p2[IX_TGL] == s.p3[IX_TGL]) && (s.p3[IX_TGL] != s.pv[IX_TGL]);
		par_ok = ^s.word;
		req = s.word[B_MODE_HI:B_MODE_LO];

		for (int i = 0; i < NPAIR; i++) begin
			if (s.pv[i]) begin
				n.scnt[i] = SW'(STRETCH);
			end else if (s.scnt[i] != '0) begin
				n.scnt[i] = s.scnt[i] - 1'b1;
			end
			if ((s.pv[i] || (s.scnt[i] != '0)) == s.arm[i]) begin
				n.gcnt[i] = '0;
			end else if (s.gcnt[i] == GW'(DEGLITCH - 1)) begin
				n.arm[i] = ~s.arm[i];
				n.gcnt[i] = '0;
			end else begin
				n.gcnt[i] = s.gcnt[i] + 1'b1;
			end
		end

		for (int c = 0; c < NCH; c++) begin
			n.fire[c] = 1'b0;
			if (s.busy[c]) begin
				if (s.dcnt[c] == (s.lng[c] ? DW'(DEP_LONG - 1) : DW'(DEP_SHORT - 1))) begin
					n.busy[c] = 1'b0;
					succ_set[c] = 1'b1;
				end else begin
					n.dcnt[c] = s.dcnt[c] + 1'b1;
				end
			end
		end

		n.dstart = 1'b0;
		n.pend = s.pend & ~diag_chan_done;

		stat_word = {RSP_STAT, |(diag_chan_fault & fault_report_channel_mask),
			(s.pend == '0), s.arm, s.succ};

		case (s.st)
			CS_IDLE: begin
				if (rx_ev) begin
					n.word = rx_word;
					n.st = CS_DECODE;
				end
			end
			CS_DECODE: begin
				n.st = CS_IDLE;
				n.resp = stat_word;
				if (!par_ok) begin
					n.resp = {RSP_FLT, FLT_FILL};
				end else begin
					case (req)
						REQ_REG: begin
							n.raddr = s.word[B_ADDR_HI:B_ADDR_LO];
							n.rrw = s.word[B_RW];
							n.st = CS_REGW;
						end
						REQ_CMD: begin
							if (s.busy == '0) begin
								n.echo = s.word[B_DATA_HI:0] & ~s.succ
									& {NCH{s.pv[IX_ENABLE]}};
								for (int c = 0; c < NCH; c++) begin
									if (n.echo[c]) begin
										n.busy[c] = 1'b1;
										n.dcnt[c] = '0;
										n.lng[c] = deploy_time_long;
										n.fire[c] = 1'b1;
									end
								end
							end
							n.resp = {RSP_CMD, 1'b0, s.pv[IX_ENABLE], s.arm, n.echo};
						end
						REQ_DIAG: begin
							if (s.word[B_WR_EN]) begin
								n.pend = s.word[B_DATA_HI:0];
								n.dchan = s.word[B_DATA_HI:0];
								n.dstart = 1'b1;
							end
						end
						default: begin
							if (s.word[B_WR_EN]) begin
								succ_clr = s.word[B_DATA_HI:0];
							end
						end
					endcase
				end
			end
			CS_REGW: begin
				n.resp = {RSP_REG, s.rrw, s.raddr, reg_rd_data};
				n.st = CS_IDLE;
			end
			default: begin
				n.st = CS_IDLE;
			end
		endcase

		n.succ = (s.succ & ~succ_clr) | succ_set;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
			s.st <= CS_IDLE;
			s.resp <= RESP_RST;
		end else begin
			s <= n;
		end
	end

	assign deploy_start = s.fire;
	assign deploy_success = s.succ;
	assign arming_status = s.arm;
	assign diag_start = s.dstart;
	assign diag_channels = s.dchan;
	assign reg_rd_addr = s.raddr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	logic [ADDR_W-1:0] word_addr;
	assign word_addr = s.word[B_ADDR_HI:B_ADDR_LO];

	sequence s_decode_ok;
		s.st == CS_DECODE && par_ok;
	endsequence

	sequence s_reg_req;
		s_decode_ok ##0 req == REQ_REG;
	endsequence

	sequence s_cmd_req;
		s_decode_ok ##0 req == REQ_CMD;
	endsequence

	chk_fault_prefix: assert property (s.st == CS_DECODE && !par_ok |=>
		s.resp[B_MODE_HI:B_MODE_LO] == RSP_FLT)
		else $error("parity fault response missing");

	chk_reg_echo: assert property (s_reg_req |=> s.st == CS_REGW ##1
		(s.resp[B_MODE_HI:B_MODE_LO] == RSP_REG && s.resp[B_ADDR_HI:B_ADDR_LO] == $past(word_addr, 2)
		&& s.resp[B_RW] == $past(s.rrw) && s.resp[B_DATA_HI:0] == $past(reg_rd_data)))
		else $error("register response fields wrong");

	chk_cmd_deploy_enable_input: assert property (s_cmd_req |=>
		(s.resp[B_MODE_HI:B_MODE_LO] == RSP_CMD && s.resp[B_WR_EN] == $past(s.pv[IX_ENABLE])))
		else $error("echo response enable bit wrong");

	chk_cmd_gated: assert property (s_cmd_req ##0 !s.pv[IX_ENABLE] |=>
		(s.resp[B_DATA_HI:0] == '0 && s.fire == '0))
		else $error("deploy accepted while enable negated");

	chk_success_block: assert property ((s.fire & $past(s.succ)) == '0)
		else $error("deploy started on channel with success set");

	chk_status_default: assert property (s_decode_ok ##0 req[1] |=>
		(s.resp[B_MODE_HI:B_MODE_LO] == RSP_STAT && s.resp[11:8] == $past(s.arm)
		&& s.resp[B_WR_EN] == ($past(s.pend) == '0)))
		else $error("status response fields wrong");

	chk_monitor_clear: assert property (s_decode_ok ##0 req == REQ_MON ##0 s.word[B_WR_EN]
		##0 succ_set == '0 |=> (s.succ & $past(s.word[B_DATA_HI:0])) == '0)
		else $error("success flag not cleared");

	chk_arm_deglitch: assert property (s.arm != $past(s.arm) |->
		$past(s.gcnt) != '0 || DEGLITCH == 1)
		else $error("arming flag moved before de-glitch expiry");

	chk_deploy_period: assert property ($rose(s.succ[0]) |-> $past(s.busy[0])
		&& $past(s.dcnt[0]) == ($past(s.lng[0]) ? DW'(DEP_LONG - 1) : DW'(DEP_SHORT - 1)))
		else $error("success flag set before end of period");
endmodule : ssr_formatter
`default_nettype wire

// *** verification/ssr_host_model.sv ***
/*
 Host SPI master model: shifts 16-bit words MSB first, returns the reply.
 Assumes the device samples mosi on rising sclk and updates miso on it.
*/
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model
	import ssr_pkg::*;
(
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// --------
	// Frame
	// --------
	// Clock stands low between frames; mosi flips once deselected
	task automatic xfer(input logic [WORD_W-1:0] tx, output logic [WORD_W-1:0] rx);
		#1.7;
		cs_n = 1'b0;
		for (int k = WORD_W - 1; k >= 0; k--) begin
			mosi = tx[k];
			#3 sclk = 1'b1;
			#3 sclk = 1'b0;
			rx[k] = miso;
		end
		#3 cs_n = 1'b1;
		mosi = ~mosi;
		#150;
	endtask : xfer
endmodule : ssr_host_model
`default_nettype wire

// *** verification/test_squib_spi_response_formatter.sv ***
/*
 Testbench for the response formatter: host frames, pins and checks.
 Assumes short deploy and timer parameters and a 6 ns link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_squib_spi_response_formatter
	import ssr_pkg::*;
;
	localparam logic [15:0] RD = 16'he000;
	logic clk = 1'b0;
	logic nrst, sclk, cs_n, mosi, miso, den, dlong, dgs;
	logic [3:0] arm, ast;
	logic [7:0] flt, msk, done, rdd, dst, dsc, dch;
	logic [4:0] rda;
	logic [15:0] r, d;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int ndg = 0;
	int ts[8], tsu[8], ns[8];
	always #5 clk = ~clk;
	assign rdd = {3'h5, rda};
	ssr_host_model ssr_host_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	ssr_formatter #(.DEP_SHORT(20), .DEP_LONG(40), .DEGLITCH(4), .STRETCH(8)) ssr_formatter_i (
		.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.deploy_enable_input(den), .arming_pair_zero_one(arm[0]),
		.arming_pair_two_three(arm[1]), .arming_pair_four_five(arm[2]),
		.arming_pair_six_seven(arm[3]), .deploy_time_long(dlong),
		.diag_chan_fault(flt), .fault_report_channel_mask(msk), .diag_chan_done(done),
		.reg_rd_data(rdd), .miso(miso), .deploy_start(dst), .deploy_success(dsc),
		.arming_status(ast), .diag_start(dgs), .diag_channels(dch), .reg_rd_addr(rda));
	// --------
	// Helpers
	// --------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dgs === 1'b1) ndg <= ndg + 1;
		for (int i = 0; i < NCH; i++) begin
			if (dst[i] === 1'b1) begin
				ts[i] <= cyc;
				ns[i] <= ns[i] + 1;
			end
			if (dsc[i] === 1'b1 && tsu[i] == 0) tsu[i] <= cyc;
		end
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	function automatic logic [15:0] near(input int a, input int e);
		return (a >= e - 1 && a <= e + 1) ? 16'h0001 : 16'h0000;
	endfunction : near
	function automatic logic [15:0] par(input logic [15:0] w);
		w[13] = ~(^{w[15:14], w[12:0]});
		return w;
	endfunction : par
	task automatic get_status(output logic [15:0] q);
		ssr_host_model_i.xfer(RD, d);
		ssr_host_model_i.xfer(RD, q);
	endtask : get_status
	task automatic cmd(input logic [15:0] w, output logic [15:0] q);
		ssr_host_model_i.xfer(par(w), d);
		ssr_host_model_i.xfer(RD, q);
	endtask : cmd
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run
	// --------
	// Scenarios
	// --------
	task automatic t_reset();
		ssr_host_model_i.xfer(RD, r);
		chk(r, 16'hd000);
		get_status(r);
		chk(r, 16'hd000);
		chk({8'h00, dsc}, 16'h0000);
	endtask : t_reset
	task automatic t_arm();
		arm = 4'ha;
		tick(2);
		chk({12'h000, ast}, 16'h0000);
		tick(20);
		get_status(r);
		chk(r, 16'hda00);
		arm = 4'h0;
		tick(8);
		chk({12'h000, ast}, 16'h000a);
		tick(30);
		chk({12'h000, ast}, 16'h0000);
	endtask : t_arm
	task automatic t_fault();
		ssr_host_model_i.xfer(16'hc000, d);
		ssr_host_model_i.xfer(RD, r);
		chk({14'h0000, r[15:14]}, 16'h0002);
		ssr_host_model_i.xfer(RD, r);
		chk(r, 16'hd000);
	endtask : t_fault
	task automatic t_deploy();
		cmd(16'h4004, r);
		chk(r & 16'hdfff, 16'h4000);
		chk(16'(ns[2]), 16'h0000);
		den = 1'b1;
		tick(8);
		cmd(16'h4004, r);
		chk(r & 16'hdfff, 16'h5004);
		tick(30);
		chk(near(tsu[2] - ts[2], 20), 16'h0001);
		dlong = 1'b1;
		cmd(16'h4002, r);
		chk(r & 16'hdfff, 16'h5002);
		tick(50);
		chk(near(tsu[1] - ts[1], 40), 16'h0001);
		get_status(r);
		chk(r, 16'hd006);
	endtask : t_deploy
	task automatic t_clear();
		cmd(16'h4004, r);
		tick(10);
		chk(16'(ns[2]), 16'h0001);
		cmd(16'hd004, r);
		chk({8'h00, dsc}, 16'h0002);
		cmd(16'h4004, r);
		tick(50);
		chk(16'(ns[2]), 16'h0002);
		chk({8'h00, dsc}, 16'h0006);
	endtask : t_clear
	task automatic t_diag();
		msk = 8'h02;
		flt = 8'h02;
		cmd(16'h9003, r);
		chk({8'h00, dch}, 16'h0003);
		chk(16'(ndg), 16'h0001);
		get_status(r);
		chk(r, 16'he006);
		msk = 8'h01;
		tick(2);
		get_status(r);
		chk(r, 16'hc006);
		done = 8'h03;
		tick(1);
		done = 8'h00;
		get_status(r);
		chk(r, 16'hd006);
	endtask : t_diag
	task automatic t_reg();
		ssr_host_model_i.xfer(16'h1300, d);
		ssr_host_model_i.xfer(RD, r);
		chk(r, 16'h13b3);
		chk({11'h000, rda}, 16'h0013);
	endtask : t_reg
	initial begin
		nrst = 1'b0;
		den = 1'b0;
		dlong = 1'b0;
		arm = 4'h0;
		flt = 8'h00;
		msk = 8'h00;
		done = 8'h00;
		tick(10);
		nrst = 1'b1;
		tick(6);
		t_reset();
		t_arm();
		t_fault();
		t_deploy();
		t_clear();
		t_diag();
		t_reg();
		complete_run();
	end
endmodule : test_squib_spi_response_formatter
`default_nettype wire
